// File: pkg/wwdt_pkg.sv
/*
 package for the windowed watchdog: option byte layout, key and read values,
 register index map, timing constants. assumes a 100 MHz core clock.
*/
package wwdt_pkg;
  // option byte fields
  localparam int OPT_LOCK_BIT = 0;
  localparam int OPT_OVF_LSB = 1;
  localparam int OPT_OVF_W = 3;
  localparam int OPT_EN_BIT = 4;
  localparam int OPT_WIN_LSB = 5;
  localparam int OPT_WIN_W = 2;
  // counter base exponent: 2^(10+sel)
  localparam int OVF_BASE_EXP = 10;
  localparam int CNT_W = 18;
  // clear register values
  localparam logic [7:0] KEY_VAL = 8'hac;
  localparam logic [7:0] RD_VAL_ON = 8'h9a;
  localparam logic [7:0] RD_VAL_OFF = 8'h1a;
  // register addresses (word index on the plain port)
  localparam logic [3:0] ADDR_CLEAR = 4'h0;
  localparam logic [3:0] ADDR_CAUSE = 4'h1;
  localparam logic [3:0] ADDR_OSC_MODE = 4'h2;
  localparam logic [3:0] ADDR_MEM_SIZE = 4'h3;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  // bit positions
  localparam int CAUSE_WDT_BIT = 4;
  localparam int OSC_STOP_BIT = 1;
  // memory check: exempt region and size granularity
  localparam logic [15:0] EXEMPT_BASE = 16'hfb00;
  localparam int MEM_GRAN_SHIFT = 10;
  // internal reset pulse
  localparam int RST_PULSE_CYC = 4;
  // low-speed tick: nominal period in ns, from core clock period in ns
  localparam int CORE_PERIOD_NS = 10;
  localparam int LS_PERIOD_NS = 30000;
  localparam int LS_DIV_CYC = LS_PERIOD_NS / CORE_PERIOD_NS;
  typedef enum logic [2:0] {
    WWDT_IDLE = 3'b001,
    WWDT_RUN = 3'b010,
    WWDT_FIRE = 3'b100
  } wwdt_state_e;
endpackage

// File: hw/wwdt_window.sv
/*
 window decode: from counter value and option fields, flags closed window
 and overflow. assumes counter counts up from zero in low-speed ticks.
*/
`timescale 1ns/1ps
module wwdt_window #(
  parameter int CW = wwdt_pkg::CNT_W
) (
  // count and option
  input wire logic [CW-1:0] count,
  input wire logic [2:0] ovf_sel,
  input wire logic [1:0] win_sel,
  // decode
  output logic win_closed,
  output logic ovf_hit
);
  logic [CW:0] period;
  logic [CW:0] close_len;
  always_comb begin
    // overflow period = 2^(10+sel) ticks
    period = (CW+1)'(1) << (wwdt_pkg::OVF_BASE_EXP + int'(ovf_sel));
    // closed part = (1 - open share) of period, at the start
    unique case (win_sel)
      2'h0: close_len = (period >> 1) + (period >> 2);
      2'h1: close_len = period >> 1;
      2'h2: close_len = period >> 2;
      default: close_len = '0;
    endcase
    win_closed = {1'b0, count} < close_len;
    // last tick before wrap still accepts a clear
    ovf_hit = {1'b0, count} >= period - (CW+1)'(1);
  end
endmodule

// File: hw/wwdt_top.sv
/*
 windowed watchdog timer core: key clear register, window and overflow
 checks, illegal fetch/access detection, cause register.
 assumes option byte is stable around reset release and the cpu flags
 single-bit writes with bit_op. all inputs synchronous to core_clk.
*/
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module wwdt_top #(
  parameter int CW = wwdt_pkg::CNT_W,
  parameter int LS_DIV = wwdt_pkg::LS_DIV_CYC
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // option byte
  input wire logic [7:0] option_byte,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic bit_op,
  output logic [7:0] reg_rdata,
  // cpu bus watch
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [15:0] data_addr,
  input wire logic data_valid,
  // power modes
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic flash_selfprog,
  // reset request out
  output logic wdt_reset_req
);
  logic enable_q, enable_d;
  logic lock_q, lock_d;
  logic [2:0] ovf_sel_q, ovf_sel_d;
  logic [1:0] win_sel_q, win_sel_d;
  logic first_done_q, first_done_d;
  logic [CW-1:0] count_q, count_d;
  logic [15:0] div_q, div_d;
  logic osc_stop_q, osc_stop_d;
  logic [7:0] mem_size_q, mem_size_d;
  logic cause_q, cause_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] pulse_q, pulse_d;
  logic loaded_q, loaded_d;
  wwdt_pkg::wwdt_state_e state_q, state_d;
  logic win_closed, ovf_hit, tick, counting, fault, clr_wr;

  // area check: mem_size_q counts 1 KiB pages from address zero
  function automatic logic out_of_area(input logic [15:0] a, input logic [7:0] sz);
    logic [23:0] lim;
    lim = 24'(sz) << wwdt_pkg::MEM_GRAN_SHIFT;
    return 24'(a) >= lim;
  endfunction

  wwdt_window #(.CW(CW)) u_win (
    .count(count_q),
    .ovf_sel(ovf_sel_q),
    .win_sel(win_sel_q),
    .win_closed(win_closed),
    .ovf_hit(ovf_hit)
  );

  assign clr_wr = reg_wr && (reg_addr == wwdt_pkg::ADDR_CLEAR);
  // low-speed tick; counting ignores flash_selfprog on purpose
  assign tick = (div_q == 16'(LS_DIV - 1));
  // halt/stop or oscillator stop freeze only when not locked
  assign counting = (state_q == wwdt_pkg::WWDT_RUN) &&
    (lock_q || !(halt_mode || stop_mode || osc_stop_q));

  always_comb begin
    fault = 1'b0;
    if (state_q == wwdt_pkg::WWDT_RUN) begin
      if (clr_wr && bit_op) fault = 1'b1;
      if (clr_wr && reg_wdata != wwdt_pkg::KEY_VAL) fault = 1'b1;
      if (clr_wr && first_done_q && win_closed) fault = 1'b1;
      if (counting && tick && ovf_hit && !clr_wr) fault = 1'b1;
      if (fetch_valid && out_of_area(fetch_addr, mem_size_q)) fault = 1'b1;
      if (data_valid && data_addr < wwdt_pkg::EXEMPT_BASE &&
          out_of_area(data_addr, mem_size_q)) fault = 1'b1;
    end
  end

  always_comb begin
    enable_d = enable_q;
    lock_d = lock_q;
    ovf_sel_d = ovf_sel_q;
    win_sel_d = win_sel_q;
    loaded_d = 1'b1;
    first_done_d = first_done_q;
    count_d = count_q;
    div_d = div_q;
    osc_stop_d = osc_stop_q;
    mem_size_d = mem_size_q;
    cause_d = cause_q;
    pulse_d = pulse_q;
    state_d = state_q;
    rdata_d = 8'h00;
    // option byte sampled once after reset release
    if (!loaded_q) begin
      enable_d = option_byte[wwdt_pkg::OPT_EN_BIT];
      lock_d = option_byte[wwdt_pkg::OPT_LOCK_BIT];
      ovf_sel_d = option_byte[wwdt_pkg::OPT_OVF_LSB +: wwdt_pkg::OPT_OVF_W];
      win_sel_d = option_byte[wwdt_pkg::OPT_WIN_LSB +: wwdt_pkg::OPT_WIN_W];
    end
    // divider holds during freeze so the count resumes in place
    if (counting) begin
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
      if (tick) count_d = count_q + CW'(1);
    end
    unique case (state_q)
      wwdt_pkg::WWDT_IDLE: begin
        if (loaded_q && enable_q) state_d = wwdt_pkg::WWDT_RUN;
      end
      wwdt_pkg::WWDT_RUN: begin
        if (fault) begin
          state_d = wwdt_pkg::WWDT_FIRE;
          pulse_d = 3'(wwdt_pkg::RST_PULSE_CYC - 1);
          cause_d = 1'b1;
        end else if (clr_wr) begin
          // divider also cleared, bounding drift to under a tick
          count_d = '0;
          div_d = 16'h0000;
          first_done_d = 1'b1;
        end
      end
      wwdt_pkg::WWDT_FIRE: begin
        if (pulse_q != 3'h0) pulse_d = pulse_q - 3'h1;
      end
      default: state_d = wwdt_pkg::WWDT_IDLE;
    endcase
    // other registers; cause flag clears by writing 0 to its bit, set wins
    if (reg_wr && !bit_op) begin
      unique case (reg_addr)
        wwdt_pkg::ADDR_OSC_MODE: osc_stop_d = reg_wdata[wwdt_pkg::OSC_STOP_BIT];
        wwdt_pkg::ADDR_MEM_SIZE: mem_size_d = reg_wdata;
        wwdt_pkg::ADDR_CAUSE: begin
          if (!reg_wdata[wwdt_pkg::CAUSE_WDT_BIT] && !fault) cause_d = 1'b0;
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        wwdt_pkg::ADDR_CLEAR: rdata_d = enable_q ? wwdt_pkg::RD_VAL_ON
                                                  : wwdt_pkg::RD_VAL_OFF;
        wwdt_pkg::ADDR_CAUSE: rdata_d = 8'(cause_q) << wwdt_pkg::CAUSE_WDT_BIT;
        wwdt_pkg::ADDR_OSC_MODE: rdata_d = 8'(osc_stop_q) << wwdt_pkg::OSC_STOP_BIT;
        wwdt_pkg::ADDR_MEM_SIZE: rdata_d = mem_size_q;
        wwdt_pkg::ADDR_COUNT: rdata_d = count_q[CW-1 -: 8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // cause flag is reset to 0 by rst_b like every register is reset; otherwise only writing 0 to its bit clears it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      enable_q <= 1'b0;
      lock_q <= 1'b0;
      ovf_sel_q <= 3'h0;
      win_sel_q <= 2'h0;
      loaded_q <= 1'b0;
      first_done_q <= 1'b0;
      count_q <= '0;
      div_q <= 16'h0000;
      osc_stop_q <= 1'b0;
      mem_size_q <= 8'hff;
      cause_q <= 1'b0;
      rdata_q <= 8'h00;
      pulse_q <= 3'h0;
      state_q <= wwdt_pkg::WWDT_IDLE;
    end else if (clk_en) begin
      enable_q <= enable_d;
      lock_q <= lock_d;
      ovf_sel_q <= ovf_sel_d;
      win_sel_q <= win_sel_d;
      loaded_q <= loaded_d;
      first_done_q <= first_done_d;
      count_q <= count_d;
      div_q <= div_d;
      osc_stop_q <= osc_stop_d;
      mem_size_q <= mem_size_d;
      cause_q <= cause_d;
      rdata_q <= rdata_d;
      pulse_q <= pulse_d;
      state_q <= state_d;
    end
  end

  assign reg_rdata = rdata_q;
  // held until the system reset asserts rst_b
  assign wdt_reset_req = (state_q == wwdt_pkg::WWDT_FIRE);
endmodule

// File: sim/wwdt_properties.sv
/* port checker for wwdt_top. assumes one clock and a bind from the bench. */
`timescale 1ns/1ps
module wwdt_properties (
  // clock, reset, option
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] option_byte,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic bit_op,
  input wire logic [7:0] reg_rdata,
  // bus watch, fault
  input wire logic [15:0] data_addr,
  input wire logic data_valid,
  input wire logic fetch_valid,
  input wire logic wdt_reset_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic up3;
  logic run;
  // option is loaded a cycle after release, so early cycles are not judged
  always_comb up_d = !rst_b ? 2'h0 : (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge core_clk) up_q <= up_d;
  assign up3 = (up_q == 2'h3);
  assign run = up3 && option_byte[wwdt_pkg::OPT_EN_BIT];
  sequence s_clr_wr;
    run && reg_wr && (reg_addr == wwdt_pkg::ADDR_CLEAR);
  endsequence
  property p_hold; wdt_reset_req |-> ##1 wdt_reset_req [*4]; endproperty
  a_hold: assert property (p_hold) else $error("fault request dropped");
  property p_bad_key; s_clr_wr ##0 (reg_wdata != wwdt_pkg::KEY_VAL) |=> wdt_reset_req; endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key not faulted");
  property p_bit_op; s_clr_wr ##0 bit_op |=> wdt_reset_req; endproperty
  a_bit_op: assert property (p_bit_op) else $error("bit write not faulted");
  property p_rd_clr;
    up3 && reg_rd && (reg_addr == wwdt_pkg::ADDR_CLEAR) |=> reg_rdata ==
      (option_byte[wwdt_pkg::OPT_EN_BIT] ? wwdt_pkg::RD_VAL_ON : wwdt_pkg::RD_VAL_OFF);
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("clear read value wrong");
  property p_rd_zero; !reg_rd |=> (reg_rdata == 8'h00); endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  property p_off; up3 && !option_byte[wwdt_pkg::OPT_EN_BIT] |-> !wdt_reset_req; endproperty
  a_off: assert property (p_off) else $error("fault while disabled");
  property p_exempt;
    run && data_valid && (data_addr >= wwdt_pkg::EXEMPT_BASE) && !reg_wr && !fetch_valid
      && !wdt_reset_req |=> !wdt_reset_req;
  endproperty
  a_exempt: assert property (p_exempt) else $error("exempt access faulted");
  property p_cause;
    wdt_reset_req && reg_rd && (reg_addr == wwdt_pkg::ADDR_CAUSE) |=>
      $past(wdt_reset_req) && reg_rdata[wwdt_pkg::CAUSE_WDT_BIT];
  endproperty
  a_cause: assert property (p_cause) else $error("cause flag not set");
endmodule

// File: sim/wwdt_cpu.sv
/* cpu side model: drives the register port. assumes calls start off the bench. */
`timescale 1ns/1ps
module wwdt_cpu (
  // clock and read data
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  // register strobes
  output logic [3:0] reg_addr = 4'h0,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic bit_op = 1'b0
);
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic b);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    bit_op <= b;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    bit_op <= 1'b0;
    // stale data is inverted so it never reads as a fresh write
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// File: sim/windowed_watchdog_timer_bench.sv
/* bench for wwdt_top with the cpu model. assumes a tick of 4 core cycles. */
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] option_byte = 8'h00;
  logic [15:0] fetch_addr = 16'h0000;
  logic [15:0] data_addr = 16'h0000;
  logic fetch_valid = 1'b0;
  logic data_valid = 1'b0;
  logic halt_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic flash_selfprog = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic reg_wr;
  logic reg_rd;
  logic bit_op;
  logic wdt_reset_req;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int o;
  wwdt_cpu u_cpu (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .bit_op);
  wwdt_top #(.LS_DIV(4)) dut (.core_clk, .rst_b, .clk_en, .option_byte, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .bit_op, .reg_rdata, .fetch_addr, .fetch_valid, .data_addr,
    .data_valid, .halt_mode, .stop_mode, .flash_selfprog, .wdt_reset_req);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // option byte: window, enable, overflow select, lock
  function automatic logic [7:0] ob(input logic [1:0] w, input logic e, input logic [2:0] s,
    input logic l);
    return {1'b0, w, e, s, l};
  endfunction
  task automatic start(input logic [7:0] opt);
    wt(1);
    rst_b <= 1'b0;
    option_byte <= opt;
    halt_mode <= 1'b0;
    stop_mode <= 1'b0;
    flash_selfprog <= 1'b0;
    clk_en <= 1'b1;
    wt(6);
    rst_b <= 1'b1;
    wt(3);
  endtask
  task automatic clr(input logic [7:0] d, input logic b);
    u_cpu.wr(wwdt_pkg::ADDR_CLEAR, d, b);
  endtask
  task automatic fchk(input logic exp);
    wt(2);
    #1 cmp({7'h00, wdt_reset_req}, {7'h00, exp});
  endtask
  task automatic ovf(input int lo, input int hi);
    n = 0;
    while (wdt_reset_req !== 1'b1 && n <= hi) begin
      @(posedge core_clk);
      #1 n++;
    end
    cmp({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask
  task automatic acc(input logic f, input logic [15:0] a);
    @(posedge core_clk);
    fetch_valid <= f;
    data_valid <= !f;
    fetch_addr <= a;
    data_addr <= a;
    @(posedge core_clk);
    fetch_valid <= 1'b0;
    data_valid <= 1'b0;
    fetch_addr <= ~a;
    data_addr <= ~a;
  endtask
  initial begin
    void'($urandom(32'h91b6f5a1));
    for (int w = 0; w < 4; w++) begin
      start(ob(w, 1'b1, 3'h1, 1'b0));
      u_cpu.rd(wwdt_pkg::ADDR_CLEAR, rv);
      cmp(rv, wwdt_pkg::RD_VAL_ON);
      clr(wwdt_pkg::KEY_VAL, 1'b0);
      fchk(1'b0);
      o = 2048 * (3 - w);
      wt(o + (8192 - o) / 2);
      clr(wwdt_pkg::KEY_VAL, 1'b0);
      fchk(1'b0);
      clr(wwdt_pkg::KEY_VAL, 1'b0);
      fchk(w != 3);
      if (w != 3) begin
        u_cpu.rd(wwdt_pkg::ADDR_CAUSE, rv);
        cmp({7'h00, rv[wwdt_pkg::CAUSE_WDT_BIT]}, 8'h01);
      end
    end
    $display("window test done");
    for (int i = 0; i < 3; i++) begin
      start(ob(2'h3, 1'b1, 3'h1, 1'b0));
      rv = $urandom;
      if (rv === wwdt_pkg::KEY_VAL) rv = 8'h00;
      clr(rv, 1'b0);
      fchk(1'b1);
      start(ob(2'h3, 1'b1, 3'h1, 1'b0));
      clr(wwdt_pkg::KEY_VAL, 1'b1);
      fchk(1'b1);
    end
    start(ob(2'h3, 1'b0, 3'h0, 1'b0));
    u_cpu.rd(wwdt_pkg::ADDR_CLEAR, rv);
    cmp(rv, wwdt_pkg::RD_VAL_OFF);
    clr(8'h55, 1'b0);
    wt(5000);
    fchk(1'b0);
    for (int f = 0; f < 2; f++) begin
      start(ob(2'h3, 1'b1, 3'h3, 1'b0));
      u_cpu.wr(wwdt_pkg::ADDR_MEM_SIZE, 8'h01, 1'b0);
      acc(1'b0, wwdt_pkg::EXEMPT_BASE + 16'($urandom % 1280));
      fchk(1'b0);
      acc(f, 16'h8000);
      fchk(1'b1);
    end
    $display("access test done");
    start(ob(2'h3, 1'b1, 3'h0, 1'b0));
    wt(2000);
    halt_mode <= 1'b1;
    wt(6000);
    fchk(1'b0);
    wt(1);
    halt_mode <= 1'b0;
    ovf(2064, 2112);
    start(ob(2'h3, 1'b1, 3'h0, 1'b1));
    stop_mode <= 1'b1;
    flash_selfprog <= 1'b1;
    ovf(4064, 4112);
    start(ob(2'h3, 1'b1, 3'h2, 1'b0));
    wt(1000);
    clr(wwdt_pkg::KEY_VAL, 1'b0);
    ovf(16352, 16400);
    // clear lands on the very tick that would overflow
    start(ob(2'h3, 1'b1, 3'h0, 1'b0));
    wt(4093);
    clr(wwdt_pkg::KEY_VAL, 1'b0);
    fchk(1'b0);
    // clock enable low freezes the count, which resumes in place
    start(ob(2'h3, 1'b1, 3'h0, 1'b0));
    clk_en <= 1'b0;
    wt(6000);
    fchk(1'b0);
    wt(1);
    clk_en <= 1'b1;
    ovf(4064, 4112);
    start(ob(2'h3, 1'b1, 3'h0, 1'b0));
    u_cpu.wr(wwdt_pkg::ADDR_OSC_MODE, 8'h02, 1'b0);
    wt(6000);
    fchk(1'b0);
    $display("mode test done");
    end_sim();
  end
endmodule
bind wwdt_top wwdt_properties u_props (.core_clk, .rst_b, .option_byte, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .bit_op, .reg_rdata, .data_addr, .data_valid, .fetch_valid, .wdt_reset_req);
